// ---- bench/lbes_host_poll.sv ----
`timescale 1ns/10ps
module lbes_host_poll
    import lbes_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Pulses the host sees on each scan
    input wire logic sensor_event_pulse,
    input wire logic raw_message_pulse,
    // Tallies of reported messages
    output int n_events,
    output int n_raw
);
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            n_events <= 0;
            n_raw <= 0;
        end else begin
            if (sensor_event_pulse === 1'h1) begin
                n_events <= n_events + 1;
            end
            if (raw_message_pulse === 1'h1) begin
                n_raw <= n_raw + 1;
            end
        end
    end
endmodule

// ---- bench/testbench.sv ----
`timescale 1ns/10ps
module testbench
    import lbes_pkg::*;
;
    logic clock = 1'h0, reset_n = 1'h0, module_recover_request = 1'h0, link_fault = 1'h0;
    logic function_request = 1'h0, rx_event_valid = 1'h0, rx_short_addr_valid = 1'h0;
    logic rx_raw_valid = 1'h0;
    logic [3:0] cmd_v = '0;
    logic [6:0] cond_v = '0;
    logic [7:0] rx_scheme = '0, rx_instance_type = 8'h11, rx_instance_number = 8'h22;
    logic [7:0] rx_short_addr = 8'h33, rx_device_group = 8'h44, rx_instance_group = 8'h55;
    logic [7:0] rx_raw_len = '0;
    logic [15:0] rx_group_mask = '0;
    logic [DATA_W-1:0] rx_event_data = '0;
    logic [31:0] rx_raw_bits = '0;
    logic function_accept, function_refuse, host_link_error, forward_frame_enable;
    logic sensor_event_pulse, raw_message_pulse;
    logic [STATUS_W-1:0] module_status_word;
    logic [7:0] event_scheme, event_source_first, event_source_second, raw_message_bit_length;
    logic [INFO_W-1:0] event_payload;
    logic [31:0] raw_message_bits;
    int error_cnt = 0, n_compared = 0, cycles = 0, n_events, n_raw;
    int cond_bit[7] = '{0, 3, 4, 5, 6, 7, 8};
    logic [7:0] schemes[6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'hff};

    always #2 clock = ~clock;

    lbes_core DUT (.clock, .reset_n, .module_recover_request, .link_fault, .function_request,
        .function_accept, .function_refuse, .cmd_start_quiescent(cmd_v[0]),
        .cmd_stop_quiescent(cmd_v[1]), .cmd_disable_ctrl(cmd_v[2]), .cmd_enable_ctrl(cmd_v[3]),
        .cond_initializing(cond_v[0]), .cond_param_disabled(cond_v[1]),
        .cond_over_voltage(cond_v[2]), .cond_missing_supply(cond_v[3]),
        .cond_short_circuit(cond_v[4]), .cond_no_bus_power(cond_v[5]),
        .cond_frame_errors(cond_v[6]), .rx_event_valid, .rx_scheme, .rx_instance_type,
        .rx_instance_number, .rx_short_addr, .rx_short_addr_valid, .rx_device_group,
        .rx_instance_group, .rx_group_mask, .rx_event_data, .rx_raw_valid, .rx_raw_len,
        .rx_raw_bits, .host_link_error, .module_status_word, .forward_frame_enable,
        .sensor_event_pulse, .event_scheme, .event_source_first, .event_source_second,
        .event_payload, .raw_message_pulse, .raw_message_bit_length, .raw_message_bits);

    lbes_host_poll host (.clock, .reset_n, .sensor_event_pulse, .raw_message_pulse,
        .n_events, .n_raw);

    task automatic conclude();
        $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            error_cnt++;
            conclude();
        end
    end

    task automatic step(int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic chk(logic [31:0] got, logic [31:0] exp, string what);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic req(logic ok);
        function_request = 1'h1;
        step(1);
        function_request = 1'h0;
        chk({function_accept, function_refuse}, {ok, !ok}, "function gate");
    endtask

    task automatic cmd(int i);
        cmd_v[i] = 1'h1;
        step(1);
        cmd_v = '0;
        step(2);
    endtask

    task automatic recover();
        module_recover_request = 1'h1;
        step(3);
        module_recover_request = 1'h0;
        step(1);
    endtask

    // Expected fields are worked out here from the scheme table
    task automatic ev(logic [7:0] sc, logic sav, logic [15:0] mask);
        logic [7:0] e1, e2;
        logic [15:0] ep;
        rx_scheme = sc;
        rx_short_addr_valid = sav;
        rx_group_mask = mask;
        rx_event_data = {2'h2, sc};
        e1 = '0;
        e2 = '0;
        case (sc)
            8'h00: begin
                e1 = 8'h11;
                e2 = 8'h22;
            end
            8'h01: begin
                e1 = 8'h33;
                e2 = 8'h11;
            end
            8'h02: begin
                e1 = 8'h33;
                e2 = 8'h22;
            end
            8'h03: begin
                e1 = 8'h44;
                e2 = 8'h11;
            end
            8'h04: begin
                e1 = 8'h55;
                e2 = 8'h11;
            end
            8'hff: begin
                e1 = 8'hff;
                for (int i = 15; i >= 0; i--) begin
                    if (mask[i]) begin
                        e1 = 8'(i);
                    end
                end
                e2 = sav ? 8'h33 : 8'hff;
            end
            default: ;
        endcase
        ep = (sc <= 8'h04) ? {6'h0, rx_event_data} : 16'h0000;
        rx_event_valid = 1'h1;
        step(1);
        rx_event_valid = 1'h0;
        chk(sensor_event_pulse, 1'h1, "event pulse");
        chk({event_scheme, event_source_first, event_source_second}, {sc, e1, e2}, "src");
        chk(event_payload, ep, "payload");
        rx_scheme = 8'h99;
        step(1);
        chk({sensor_event_pulse, event_source_first}, {1'h0, e1}, "pulse end, hold");
    endtask

    initial begin
        step(20);
        reset_n = 1'h1;
        step(2);
        chk(module_status_word, STATUS_RESET, "status idle");
        chk(host_link_error, 1'h0, "link idle");
        foreach (cond_bit[i]) begin
            cond_v = 7'h1 << i;
            step(2);
            chk(module_status_word, 32'h1 << cond_bit[i], "condition bit");
        end
        cond_v = '0;
        link_fault = 1'h1;
        step(2);
        chk(host_link_error, 1'h1, "link fault");
        link_fault = 1'h0;
        step(2);
        chk(host_link_error, 1'h0, "link ok");
        req(1'h1);
        cmd(0);
        chk(module_status_word, 32'h2, "quiescent");
        req(1'h0);
        recover();
        chk(module_status_word, 32'h0, "recover quiescent");
        cmd(2);
        chk({module_status_word, forward_frame_enable}, {32'h4, 1'h0}, "disabled");
        req(1'h0);
        cmd(3);
        chk({module_status_word, forward_frame_enable}, {32'h0, 1'h1}, "enable cmd");
        cmd(0);
        cmd(1);
        chk(module_status_word, 32'h0, "stop cmd");
        cmd(0);
        cmd(2);
        chk(module_status_word, 32'h6, "both modes");
        recover();
        chk(module_status_word, 32'h0, "recover both");
        req(1'h1);
        foreach (schemes[i]) ev(schemes[i], 1'h1, 16'h0a40);
        ev(8'hff, 1'h0, 16'h0000);
        ev(8'hff, 1'h1, 16'h8000);
        ev(8'h07, 1'h1, 16'h0001);
        rx_event_valid = 1'h1;
        step(2);
        rx_event_valid = 1'h0;
        step(2);
        chk(n_events, 32'd11, "event count");
        rx_raw_len = 8'h1d;
        rx_raw_bits = 32'h1a2b3c4d;
        rx_raw_valid = 1'h1;
        step(1);
        rx_raw_valid = 1'h0;
        rx_raw_bits = '0;
        chk(raw_message_pulse, 1'h1, "raw pulse");
        chk({raw_message_bit_length, raw_message_bits}, {8'h1d, 32'h1a2b3c4d}, "raw");
        step(1);
        chk({raw_message_pulse, raw_message_bits}, {1'h0, 32'h1a2b3c4d}, "raw hold");
        chk(n_raw, 32'd1, "raw count");
        conclude();
    end
endmodule

// ---- core/lbes_core.sv ----
// Behaviour
// - Quiescent or disabled refuses other function requests
// - Recover rising edge clears quiescent and disabled
// - Bus stop/enable commands also leave those states
// - Host link error flag follows link failure
// - Status word zero when all is well
// - Sensor event flag pulses one cycle
// - First source field chosen by scheme
// - Second source field chosen by scheme
// - Schemes up to 4 carry ten data bits
// - Power-cycle event payload reads zero
// - Group field gives lowest group or 0xff
// - Short address field gives address or 0xff
// - Raw message flag pulses one cycle
// - Raw message length and bits passed uninterpreted
// - Every received sensor event is reported
// - Status bit 1 marks quiescent mode
// - Status bit 2 marks disabled, responses only
`timescale 1ns/10ps
module lbes_core
    import lbes_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Host control
    input wire logic module_recover_request,
    input wire logic link_fault,
    input wire logic function_request,
    output logic function_accept,
    output logic function_refuse,
    // Bus commands from other controllers, one-cycle pulses
    input wire logic cmd_start_quiescent,
    input wire logic cmd_stop_quiescent,
    input wire logic cmd_disable_ctrl,
    input wire logic cmd_enable_ctrl,
    // Module conditions
    input wire logic cond_initializing,
    input wire logic cond_param_disabled,
    input wire logic cond_over_voltage,
    input wire logic cond_missing_supply,
    input wire logic cond_short_circuit,
    input wire logic cond_no_bus_power,
    input wire logic cond_frame_errors,
    // Received sensor event
    input wire logic rx_event_valid,
    input wire logic [7:0] rx_scheme,
    input wire logic [7:0] rx_instance_type,
    input wire logic [7:0] rx_instance_number,
    input wire logic [7:0] rx_short_addr,
    input wire logic rx_short_addr_valid,
    input wire logic [7:0] rx_device_group,
    input wire logic [7:0] rx_instance_group,
    input wire logic [15:0] rx_group_mask,
    input wire logic [DATA_W-1:0] rx_event_data,
    // Received reserved message
    input wire logic rx_raw_valid,
    input wire logic [7:0] rx_raw_len,
    input wire logic [31:0] rx_raw_bits,
    // Status outputs
    output logic host_link_error,
    output logic [STATUS_W-1:0] module_status_word,
    output logic forward_frame_enable,
    // Event outputs
    output logic sensor_event_pulse,
    output logic [7:0] event_scheme,
    output logic [7:0] event_source_first,
    output logic [7:0] event_source_second,
    output logic [INFO_W-1:0] event_payload,
    // Raw message outputs
    output logic raw_message_pulse,
    output logic [7:0] raw_message_bit_length,
    output logic [31:0] raw_message_bits
);
    logic recover_prev_q, recover_prev_d;
    logic quiescent_q, quiescent_d;
    logic disabled_q, disabled_d;
    logic [STATUS_W-1:0] status_q, status_d;
    logic link_err_q, link_err_d;
    logic fwd_en_q, fwd_en_d;
    logic accept_q, accept_d;
    logic refuse_q, refuse_d;
    logic ev_pulse_q, ev_pulse_d;
    logic [7:0] scheme_q, scheme_d;
    logic [7:0] src1_q, src1_d;
    logic [7:0] src2_q, src2_d;
    logic [INFO_W-1:0] info_q, info_d;
    logic raw_pulse_q, raw_pulse_d;
    logic [7:0] raw_len_q, raw_len_d;
    logic [31:0] raw_bits_q, raw_bits_d;
    logic [7:0] map_src1;
    logic [7:0] map_src2;
    logic [INFO_W-1:0] map_info;
    logic recover_edge;
    logic blocked;

    lbes_event_map u_map (
        .scheme(rx_scheme),
        .instance_type(rx_instance_type),
        .instance_number(rx_instance_number),
        .short_addr(rx_short_addr),
        .short_addr_valid(rx_short_addr_valid),
        .device_group(rx_device_group),
        .instance_group(rx_instance_group),
        .group_mask(rx_group_mask),
        .event_data(rx_event_data),
        .src_first(map_src1),
        .src_second(map_src2),
        .payload(map_info)
    );

    assign recover_edge = module_recover_request && !recover_prev_q;
    assign blocked = quiescent_q || disabled_q;

    // Mode flags: a start command in the same cycle as a recovery wins
    always_comb begin
        recover_prev_d = module_recover_request;
        quiescent_d = quiescent_q;
        disabled_d = disabled_q;
        if (recover_edge || cmd_stop_quiescent) begin
            quiescent_d = 1'b0;
        end
        if (recover_edge || cmd_enable_ctrl) begin
            disabled_d = 1'b0;
        end
        if (cmd_start_quiescent) begin
            quiescent_d = 1'b1;
        end
        if (cmd_disable_ctrl) begin
            disabled_d = 1'b1;
        end
    end

    // Status word and request gating
    always_comb begin
        status_d = STATUS_RESET;
        status_d[ST_INIT] = cond_initializing;
        status_d[ST_QUIESCENT] = quiescent_d;
        status_d[ST_DISABLED] = disabled_d;
        status_d[ST_PARAM_OFF] = cond_param_disabled;
        status_d[ST_OVER_VOLT] = cond_over_voltage;
        status_d[ST_MISSING_V] = cond_missing_supply;
        status_d[ST_SHORT] = cond_short_circuit;
        status_d[ST_NO_POWER] = cond_no_bus_power;
        status_d[ST_FRAME_ERR] = cond_frame_errors;
        link_err_d = link_fault;
        fwd_en_d = !disabled_d && !cond_param_disabled;
        accept_d = function_request && !blocked;
        refuse_d = function_request && blocked;
    end

    // Event and raw message capture
    always_comb begin
        ev_pulse_d = rx_event_valid;
        scheme_d = scheme_q;
        src1_d = src1_q;
        src2_d = src2_q;
        info_d = info_q;
        if (rx_event_valid) begin
            scheme_d = rx_scheme;
            src1_d = map_src1;
            src2_d = map_src2;
            info_d = map_info;
        end
        raw_pulse_d = rx_raw_valid;
        raw_len_d = raw_len_q;
        raw_bits_d = raw_bits_q;
        if (rx_raw_valid) begin
            raw_len_d = rx_raw_len;
            raw_bits_d = rx_raw_bits;
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            recover_prev_q <= 1'b0;
            quiescent_q <= 1'b0;
            disabled_q <= 1'b0;
            status_q <= STATUS_RESET;
            link_err_q <= 1'b0;
            fwd_en_q <= 1'b0;
            accept_q <= 1'b0;
            refuse_q <= 1'b0;
            ev_pulse_q <= 1'b0;
            scheme_q <= 8'h00;
            src1_q <= 8'h00;
            src2_q <= 8'h00;
            info_q <= 16'h0000;
            raw_pulse_q <= 1'b0;
            raw_len_q <= 8'h00;
            raw_bits_q <= 32'h00000000;
        end else begin
            recover_prev_q <= recover_prev_d;
            quiescent_q <= quiescent_d;
            disabled_q <= disabled_d;
            status_q <= status_d;
            link_err_q <= link_err_d;
            fwd_en_q <= fwd_en_d;
            accept_q <= accept_d;
            refuse_q <= refuse_d;
            ev_pulse_q <= ev_pulse_d;
            scheme_q <= scheme_d;
            src1_q <= src1_d;
            src2_q <= src2_d;
            info_q <= info_d;
            raw_pulse_q <= raw_pulse_d;
            raw_len_q <= raw_len_d;
            raw_bits_q <= raw_bits_d;
        end
    end

    assign function_accept = accept_q;
    assign function_refuse = refuse_q;
    assign host_link_error = link_err_q;
    assign module_status_word = status_q;
    assign forward_frame_enable = fwd_en_q;
    assign sensor_event_pulse = ev_pulse_q;
    assign event_scheme = scheme_q;
    assign event_source_first = src1_q;
    assign event_source_second = src2_q;
    assign event_payload = info_q;
    assign raw_message_pulse = raw_pulse_q;
    assign raw_message_bit_length = raw_len_q;
    assign raw_message_bits = raw_bits_q;

    a_refuse_blocked: assert property (@(posedge clock) disable iff (!reset_n)
        function_request && (status_q[ST_QUIESCENT] || status_q[ST_DISABLED])
        |=> function_refuse && !function_accept)
        else $error("request taken while quiescent or disabled");

    a_recover_clears: assert property (@(posedge clock) disable iff (!reset_n)
        $rose(module_recover_request) && !cmd_start_quiescent && !cmd_disable_ctrl
        |=> !module_status_word[ST_QUIESCENT] && !module_status_word[ST_DISABLED])
        else $error("recovery edge did not clear mode bits");

    a_cmd_leaves: assert property (@(posedge clock) disable iff (!reset_n)
        cmd_stop_quiescent && !cmd_start_quiescent |=> !module_status_word[ST_QUIESCENT])
        else $error("stop command did not leave quiescent");

    a_link_error: assert property (@(posedge clock) disable iff (!reset_n)
        ##1 host_link_error == $past(link_fault))
        else $error("link error flag wrong");

    a_status_idle: assert property (@(posedge clock) disable iff (!reset_n)
        module_status_word[STATUS_W-1:ST_FRAME_ERR+1] == '0)
        else $error("reserved status bits set");

    a_event_pulse: assert property (@(posedge clock) disable iff (!reset_n)
        ##1 sensor_event_pulse == $past(rx_event_valid))
        else $error("event flag not one cycle per event");

    a_power_zero: assert property (@(posedge clock) disable iff (!reset_n)
        rx_event_valid && rx_scheme == SCHEME_POWER
        |=> sensor_event_pulse && event_payload == INFO_POWER)
        else $error("power-cycle payload not zero");

    a_data_low: assert property (@(posedge clock) disable iff (!reset_n)
        rx_event_valid && rx_scheme <= SCHEME_INST_GROUP
        |=> event_payload == {6'h00, $past(rx_event_data)})
        else $error("event data not in low ten bits");

    a_addr_none: assert property (@(posedge clock) disable iff (!reset_n)
        rx_event_valid && rx_scheme == SCHEME_POWER && !rx_short_addr_valid
        |=> event_source_second == NO_VALUE)
        else $error("invalid short address not reported as ff");

    a_raw_pass: assert property (@(posedge clock) disable iff (!reset_n)
        rx_raw_valid |=> raw_message_pulse && raw_message_bits == $past(rx_raw_bits)
            && raw_message_bit_length == $past(rx_raw_len))
        else $error("raw message not passed through");

    a_fields_hold: assert property (@(posedge clock) disable iff (!reset_n)
        !rx_event_valid |=> $stable(event_source_first) && $stable(event_payload)
            && $stable(event_source_second) && $stable(event_scheme))
        else $error("event fields changed without event");

    a_src_inst: assert property (@(posedge clock) disable iff (!reset_n)
        rx_event_valid && rx_scheme == SCHEME_INST |=> event_source_first == $past(rx_instance_type)
            && event_source_second == $past(rx_instance_number))
        else $error("scheme 0 source fields wrong");

    a_src_addr: assert property (@(posedge clock) disable iff (!reset_n)
        rx_event_valid && rx_scheme == SCHEME_ADDR_NUM |=> event_source_first == $past(rx_short_addr)
            && event_source_second == $past(rx_instance_number))
        else $error("scheme 2 source fields wrong");

    a_group_none: assert property (@(posedge clock) disable iff (!reset_n)
        rx_event_valid && rx_scheme == SCHEME_POWER && rx_group_mask == 16'h0000
        |=> event_source_first == NO_VALUE)
        else $error("missing group not reported as ff");

    a_raw_pulse: assert property (@(posedge clock) disable iff (!reset_n)
        ##1 raw_message_pulse == $past(rx_raw_valid))
        else $error("raw flag not one cycle per message");

    a_fwd_disabled: assert property (@(posedge clock) disable iff (!reset_n)
        module_status_word[ST_DISABLED] |-> !forward_frame_enable)
        else $error("forward frames allowed while disabled");

    a_enable_leaves: assert property (@(posedge clock) disable iff (!reset_n)
        cmd_enable_ctrl && !cmd_disable_ctrl |=> !module_status_word[ST_DISABLED])
        else $error("enable command did not leave disabled");
endmodule

// ---- core/lbes_event_map.sv ----
`timescale 1ns/10ps
module lbes_event_map
    import lbes_pkg::*;
(
    // Received event fields
    input wire logic [7:0] scheme,
    input wire logic [7:0] instance_type,
    input wire logic [7:0] instance_number,
    input wire logic [7:0] short_addr,
    input wire logic short_addr_valid,
    input wire logic [7:0] device_group,
    input wire logic [7:0] instance_group,
    input wire logic [15:0] group_mask,
    input wire logic [DATA_W-1:0] event_data,
    // Mapped outputs
    output logic [7:0] src_first,
    output logic [7:0] src_second,
    output logic [INFO_W-1:0] payload
);
    // Lowest member group, or the no-value code
    function automatic logic [7:0] lowest_group(input logic [15:0] mask);
        logic [7:0] g;
        g = NO_VALUE;
        for (int i = GROUP_N - 1; i >= 0; i--) begin
            if (mask[i]) begin
                g = 8'(i);
            end
        end
        return g;
    endfunction

    always_comb begin
        src_first = 8'h00;
        src_second = 8'h00;
        payload = {{(INFO_W - DATA_W){1'b0}}, event_data};
        case (scheme)
            SCHEME_INST: begin
                src_first = instance_type;
                src_second = instance_number;
            end
            SCHEME_ADDR_TYPE: begin
                src_first = short_addr;
                src_second = instance_type;
            end
            SCHEME_ADDR_NUM: begin
                src_first = short_addr;
                src_second = instance_number;
            end
            SCHEME_DEV_GROUP: begin
                src_first = device_group;
                src_second = instance_type;
            end
            SCHEME_INST_GROUP: begin
                src_first = instance_group;
                src_second = instance_type;
            end
            SCHEME_POWER: begin
                src_first = lowest_group(group_mask);
                src_second = short_addr_valid ? short_addr : NO_VALUE;
                payload = INFO_POWER;
            end
            default: begin
                payload = {INFO_W{1'b0}};
            end
        endcase
    end
endmodule

// ---- core/lbes_pkg.sv ----
package lbes_pkg;
    localparam int STATUS_W = 32;
    localparam int INFO_W = 16;
    localparam int DATA_W = 10;
    localparam int GROUP_N = 16;
    localparam logic [7:0] SCHEME_INST = 8'h00;
    localparam logic [7:0] SCHEME_ADDR_TYPE = 8'h01;
    localparam logic [7:0] SCHEME_ADDR_NUM = 8'h02;
    localparam logic [7:0] SCHEME_DEV_GROUP = 8'h03;
    localparam logic [7:0] SCHEME_INST_GROUP = 8'h04;
    localparam logic [7:0] SCHEME_POWER = 8'hff;
    localparam logic [7:0] NO_VALUE = 8'hff;
    localparam logic [15:0] INFO_POWER = 16'h0000;
    localparam logic [31:0] STATUS_RESET = 32'h00000000;
    localparam int ST_INIT = 0;
    localparam int ST_QUIESCENT = 1;
    localparam int ST_DISABLED = 2;
    localparam int ST_PARAM_OFF = 3;
    localparam int ST_OVER_VOLT = 4;
    localparam int ST_MISSING_V = 5;
    localparam int ST_SHORT = 6;
    localparam int ST_NO_POWER = 7;
    localparam int ST_FRAME_ERR = 8;
endpackage
